/* src/dam_pkg.sv */
/*
 * Shared constants for the address-generator mode control block: register
 * offsets, mode bit positions, register kinds and word sizes.
 * Assumes a 32-bit AXI4-Lite register bus and a 4-bit byte address.
 */
package dam_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0]  OFS_MODE   = 4'h0;
    localparam logic [3:0]  OFS_MASK   = 4'h4;
    localparam logic [3:0]  OFS_FORCE  = 4'h8;
    localparam logic [3:0]  OFS_STATUS = 4'hC;

    // ****************************************************************
    // Mode control fields
    // ****************************************************************
    localparam int          MODE_W       = 10;
    localparam int          B_SIMD       = 0;
    localparam int          B_BITREV1    = 1;
    localparam int          B_BITREV2    = 2;
    localparam int          B_BANK_LSB   = 3;
    localparam int          BANK_W       = 4;
    localparam int          B_CIRCULAR   = 7;
    localparam int          B_BCAST1     = 8;
    localparam int          B_BCAST9     = 9;
    localparam logic [9:0]  MODE_RST     = 10'h000;
    localparam logic [9:0]  MASK_RST     = 10'h000;
    localparam logic [9:0]  FORCE_RST    = 10'h000;

    // ****************************************************************
    // Address generator constants
    // ****************************************************************
    localparam logic [1:0]  K_INDEX  = 2'h0;
    localparam logic [1:0]  K_MODIFY = 2'h1;
    localparam logic [1:0]  K_LENGTH = 2'h2;
    localparam logic [1:0]  K_BASE   = 2'h3;
    localparam logic [1:0]  WS_NORMAL = 2'h2;
    localparam logic [1:0]  WS_SHORT  = 2'h3;
    localparam logic [31:0] NW_STEP  = 32'h0000_0001;
    localparam logic [31:0] SW_STEP  = 32'h0000_0002;
    localparam logic [3:0]  GEN1_BR_INDEX = 4'h0;
    localparam logic [3:0]  GEN2_BR_INDEX = 4'h8;
    localparam int          B_GEN    = 3;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* src/dam_mode_ctrl.sv */
/*
 * Mode control and address output of the two data address generators:
 * bit reversal, SIMD dual addressing, register transfers, alternate banks
 * and mode masking on interrupt entry, with an AXI4-Lite register slave.
 * Assumes the core sequencer drives one-cycle request strobes synchronous
 * to aclk and places an unrelated instruction after a bank switch.
 */
// Functional notes
// - first generator bit-reverses index zero output
// - second generator bit-reverses index eight output
// - only bus address reversed, register stays normal
// - reversal on post-modify, addition on unreversed
// - SIMD mode while SIMD enable bit set
// - SIMD access drives explicit and implicit address
// - normal-word implicit address is explicit plus one
// - short-word implicit address is explicit plus two
// - pre-modify uses modify plus index, no update
// - odd and even explicit addresses both accepted
// - SIMD dual addressing only normal, short words
// - generator-to-data move writes both elements in SIMD mode, only the first otherwise
// - moves into generator gated by first element in SIMD mode only
// - inactive alternate registers stay unchanged
// - bank select takes effect one cycle later
// - four independent bank groups of four registers
// - interrupt entry forces masked mode bits
// - circular off ignores base/length; base loads index
`timescale 1ns/1ps
module dam_mode_ctrl
    import dam_pkg::*;
#(
    parameter int AW = 4
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          op_valid,
    input  wire logic [3:0]    op_index,
    input  wire logic [3:0]    op_modify,
    input  wire logic          op_pre,
    input  wire logic [1:0]    op_wsize,
    input  wire logic          wr_valid,
    input  wire logic [1:0]    wr_kind,
    input  wire logic [3:0]    wr_num,
    input  wire logic [31:0]   wr_data,
    input  wire logic          wr_cond_x,
    input  wire logic          rd_valid,
    input  wire logic [1:0]    rd_kind,
    input  wire logic [3:0]    rd_num,
    input  wire logic          isr_entry,
    output logic               bus_valid,
    output logic               bus_pm,
    output logic               bus_dual,
    output logic [31:0]        bus_addr_explicit,
    output logic [31:0]        bus_addr_implicit,
    output logic               dreg_x_we,
    output logic               dreg_y_we,
    output logic [31:0]        dreg_data,
    output logic [MODE_W-1:0]  mode_bits
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:0][1:0][15:0][31:0] regs;
        logic [MODE_W-1:0]           mode;
        logic [MODE_W-1:0]           mask;
        logic [MODE_W-1:0]           force_val;
        logic [BANK_W-1:0]           bank_act;
        logic                        awready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        bus_valid;
        logic                        bus_pm;
        logic                        bus_dual;
        logic [31:0]                 addr_e;
        logic [31:0]                 addr_i;
        logic                        dx_we;
        logic                        dy_we;
        logic [31:0]                 ddata;
    } dam_state_t;

    dam_state_t state_reg;
    dam_state_t state_next;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] bit_rev(input logic [31:0] a);
        logic [31:0] r;
        r = '0;
        for (int n = 0; n < 32; n++) begin
            r[31-n] = a[n];
        end
        return r;
    endfunction

    function automatic logic [MODE_W-1:0] merge_strb(input logic [MODE_W-1:0] old,
                                                    input logic [31:0] d,
                                                    input logic [3:0] s);
        logic [31:0] w;
        w = 32'({{(32-MODE_W){1'b0}}, old});
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                w[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return w[MODE_W-1:0];
    endfunction

    // Alternate bank in use for a register number: one select per group of four.
    function automatic logic bank_of(input logic [BANK_W-1:0] act, input logic [3:0] num);
        return act[num[3:2]];
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0] idx;
        logic [31:0] mdf;
        logic [31:0] upd;
        logic [31:0] bl;
        logic        bk;
        logic        rev;
        logic        dual;
        state_next = state_reg;
        idx = '0;
        mdf = '0;
        upd = '0;
        bl  = '0;
        bk  = 1'b0;
        rev = 1'b0;
        dual = 1'b0;

        // Bank selects reach the register file one cycle after the mode write.
        state_next.bank_act = state_reg.mode[B_BANK_LSB +: BANK_W];

        // AXI4-Lite write: address and data are taken together.
        // A write whose response is still pending blocks the next address, so two
        // writes never overlap and the response always follows both channels.
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (state_reg.awready) begin
            state_next.awready = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            if (s_axi_awaddr == OFS_MODE) begin
                state_next.mode = merge_strb(state_reg.mode, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == OFS_MASK) begin
                state_next.mask = merge_strb(state_reg.mask, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == OFS_FORCE) begin
                state_next.force_val = merge_strb(state_reg.force_val, s_axi_wdata,
                                                  s_axi_wstrb);
            end else if (s_axi_awaddr != OFS_STATUS) begin
                state_next.bresp = RESP_SLVERR;
            end
        end else if (s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid) begin
            state_next.awready = 1'b1;
        end

        // Interrupt entry overrides the selected mode bits.
        if (isr_entry) begin
            state_next.mode = (state_next.mode & ~state_reg.mask)
                            | (state_reg.force_val & state_reg.mask);
        end

        // AXI4-Lite read.
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (state_reg.arready) begin
            state_next.arready = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rresp   = RESP_OKAY;
            state_next.rdata   = '0;
            if (s_axi_araddr == OFS_MODE) begin
                state_next.rdata[MODE_W-1:0] = state_reg.mode;
            end else if (s_axi_araddr == OFS_MASK) begin
                state_next.rdata[MODE_W-1:0] = state_reg.mask;
            end else if (s_axi_araddr == OFS_FORCE) begin
                state_next.rdata[MODE_W-1:0] = state_reg.force_val;
            end else if (s_axi_araddr == OFS_STATUS) begin
                state_next.rdata[BANK_W-1:0] = state_reg.bank_act;
            end else begin
                state_next.rresp = RESP_SLVERR;
            end
        end else if (s_axi_arvalid && !state_reg.rvalid) begin
            state_next.arready = 1'b1;
        end

        // Memory address generation.
        // Pre-modify addresses are never reversed and leave the index register alone.
        // Only post-modify accesses through index zero or eight see the reversal,
        // and the stored index always advances in normal bit order.
        state_next.bus_valid = 1'b0;
        if (op_valid) begin
            bk  = bank_of(state_reg.bank_act, op_index);
            idx = state_reg.regs[K_INDEX][bk][op_index];
            mdf = state_reg.regs[K_MODIFY][bank_of(state_reg.bank_act, op_modify)][op_modify];
            rev = (state_reg.mode[B_BITREV1] && op_index == GEN1_BR_INDEX)
               || (state_reg.mode[B_BITREV2] && op_index == GEN2_BR_INDEX);
            dual = state_reg.mode[B_SIMD]
                && (op_wsize == WS_NORMAL || op_wsize == WS_SHORT);
            state_next.bus_valid = 1'b1;
            state_next.bus_pm    = op_index[B_GEN];
            state_next.bus_dual  = dual;
            if (op_pre) begin
                state_next.addr_e = mdf + idx;
            end else begin
                state_next.addr_e = rev ? bit_rev(idx) : idx;
                upd = idx + mdf;
                bl  = state_reg.regs[K_BASE][bk][op_index]
                    + state_reg.regs[K_LENGTH][bk][op_index];
                if (state_reg.mode[B_CIRCULAR]
                    && state_reg.regs[K_LENGTH][bk][op_index] != '0) begin
                    if (!mdf[31] && upd >= bl) begin
                        upd = upd - state_reg.regs[K_LENGTH][bk][op_index];
                    end else if (mdf[31] && upd < state_reg.regs[K_BASE][bk][op_index]) begin
                        upd = upd + state_reg.regs[K_LENGTH][bk][op_index];
                    end
                end
                state_next.regs[K_INDEX][bk][op_index] = upd;
            end
            // Implicit address follows the explicit one; parity is not checked.
            state_next.addr_i = state_next.addr_e
                              + ((op_wsize == WS_SHORT) ? SW_STEP : NW_STEP);
        end

        // Generator register to data register file.
        state_next.dx_we = 1'b0;
        state_next.dy_we = 1'b0;
        if (rd_valid) begin
            state_next.dx_we = 1'b1;
            state_next.dy_we = state_reg.mode[B_SIMD];
            state_next.ddata = state_reg.regs[rd_kind][bank_of(state_reg.bank_act, rd_num)][rd_num];
        end

        // Writes into generator registers touch only the active bank.
        if (wr_valid && (wr_cond_x || !state_reg.mode[B_SIMD])) begin
            bk = bank_of(state_reg.bank_act, wr_num);
            state_next.regs[wr_kind][bk][wr_num] = wr_data;
            if (wr_kind == K_BASE) begin
                state_next.regs[K_INDEX][bk][wr_num] = wr_data;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg           <= '0;
            state_reg.mode      <= MODE_RST;
            state_reg.mask      <= MASK_RST;
            state_reg.force_val <= FORCE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready     = state_reg.awready;
    assign s_axi_wready      = state_reg.awready;
    assign s_axi_bvalid      = state_reg.bvalid;
    assign s_axi_bresp       = state_reg.bresp;
    assign s_axi_arready     = state_reg.arready;
    assign s_axi_rvalid      = state_reg.rvalid;
    assign s_axi_rdata       = state_reg.rdata;
    assign s_axi_rresp       = state_reg.rresp;
    assign bus_valid         = state_reg.bus_valid;
    assign bus_pm            = state_reg.bus_pm;
    assign bus_dual          = state_reg.bus_dual;
    assign bus_addr_explicit = state_reg.addr_e;
    assign bus_addr_implicit = state_reg.addr_i;
    assign dreg_x_we         = state_reg.dx_we;
    assign dreg_y_we         = state_reg.dy_we;
    assign dreg_data         = state_reg.ddata;
    assign mode_bits         = state_reg.mode;

endmodule

/* dv/dam_checker.sv */
/*
 * Port checker for the address-generator mode control block.
 * Assumes it is bound to dam_mode_ctrl and sees only that module's ports.
 */
`timescale 1ns/1ps
module dam_checker
    import dam_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              op_valid,
    input wire logic [3:0]        op_index,
    input wire logic [1:0]        op_wsize,
    input wire logic              rd_valid,
    input wire logic              bus_valid,
    input wire logic              bus_pm,
    input wire logic              bus_dual,
    input wire logic [31:0]       bus_addr_explicit,
    input wire logic [31:0]       bus_addr_implicit,
    input wire logic              dreg_x_we,
    input wire logic              dreg_y_we,
    input wire logic [MODE_W-1:0] mode_bits
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_simd_rd;
        rd_valid && mode_bits[B_SIMD] ##1 dreg_x_we;
    endsequence

    a_op_answer: assert property (op_valid |=> bus_valid)
        else $error("no address after an access request");
    a_bus_quiet: assert property (!op_valid |=> !bus_valid)
        else $error("address strobe without a request");
    a_pm_select: assert property (op_valid |=> bus_pm == $past(op_index[B_GEN]))
        else $error("wrong bus for the index register");
    a_dual_flag: assert property (op_valid |=>
        bus_dual == ($past(mode_bits[B_SIMD]) && $past(op_wsize[1])))
        else $error("dual flag does not follow mode and word size");
    a_normal_step: assert property (op_valid && op_wsize == WS_NORMAL |=>
        bus_addr_implicit == bus_addr_explicit + NW_STEP)
        else $error("normal word companion address wrong");
    a_short_step: assert property (op_valid && op_wsize == WS_SHORT |=>
        bus_addr_implicit == bus_addr_explicit + SW_STEP)
        else $error("short word companion address wrong");
    a_both_elements: assert property (s_simd_rd |-> dreg_y_we)
        else $error("second element not written in SIMD move");
    a_single_elem: assert property (rd_valid && !mode_bits[B_SIMD] |=>
        dreg_x_we && !dreg_y_we)
        else $error("wrong element writes in single-data move");
    a_y_with_x: assert property (dreg_y_we |-> dreg_x_we)
        else $error("second element written alone");
endmodule

bind dam_mode_ctrl dam_checker u_chk (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .op_valid          (op_valid),
    .op_index          (op_index),
    .op_wsize          (op_wsize),
    .rd_valid          (rd_valid),
    .bus_valid         (bus_valid),
    .bus_pm            (bus_pm),
    .bus_dual          (bus_dual),
    .bus_addr_explicit (bus_addr_explicit),
    .bus_addr_implicit (bus_addr_implicit),
    .dreg_x_we         (dreg_x_we),
    .dreg_y_we         (dreg_y_we),
    .mode_bits         (mode_bits)
);

/* dv/dam_mem_model.sv */
/*
 * Data and program memory bus model: counts companion transfers.
 * Assumes registered address strobes synchronous to aclk.
 */
`timescale 1ns/1ps
module dam_mem_model (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        bus_valid,
    input wire logic        bus_dual,
    output logic [7:0]      imp_count
);
    // A dual access moves a second word at the companion address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imp_count <= 8'h00;
        end else if (bus_valid && bus_dual) begin
            imp_count <= imp_count + 8'h01;
        end
    end
endmodule

/* dv/testbench.sv */
/*
 * Self-checking bench for dam_mode_ctrl: access table, then moves, banks,
 * masking on service entry. Assumes dam_checker is bound by its own file.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    import dam_pkg::*;
    typedef struct {
        logic [9:0] mode; logic [3:0] idx; logic pre; logic [1:0] ws;
        logic [31:0] i; logic [31:0] m; logic rv; logic dual;
    } dam_row_t;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, op_valid = 0;
    logic op_pre = 0, wr_valid = 0, wr_cond_x = 1, rd_valid = 0, isr_entry = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [3:0] op_index = 0, op_modify = 0, wr_num = 0, rd_num = 0;
    logic [1:0] op_wsize = 0, wr_kind = 0, rd_kind = 0;
    logic [31:0] s_axi_wdata = 0, wr_data = 0, e, st, rd_got;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic bus_valid, bus_pm, bus_dual, dreg_x_we, dreg_y_we;
    logic [1:0] s_axi_bresp, s_axi_rresp, b_got, r_got;
    logic [31:0] s_axi_rdata, bus_addr_explicit, bus_addr_implicit, dreg_data;
    logic [MODE_W-1:0] mode_bits;
    logic [7:0] imp_count, n_imp = 0;
    int n_errors = 0, compares = 0;
    dam_row_t r;
    dam_row_t rows [9] = '{
        '{10'h000, 4'h3, 1'h0, 2'h0, 32'h100, 32'h4, 1'h0, 1'h0},
        '{10'h001, 4'h5, 1'h0, 2'h2, 32'h201, 32'h2, 1'h0, 1'h1},
        '{10'h001, 4'h9, 1'h0, 2'h3, 32'h400, 32'h4, 1'h0, 1'h1},
        '{10'h001, 4'h2, 1'h1, 2'h2, 32'h10, 32'h20, 1'h0, 1'h1},
        '{10'h001, 4'h1, 1'h0, 2'h1, 32'h30, 32'h1, 1'h0, 1'h0},
        '{10'h002, 4'h0, 1'h0, 2'h0, 32'h83000, 32'h4000000, 1'h1, 1'h0},
        '{10'h004, 4'h8, 1'h0, 2'h0, 32'h83000, 32'h4000000, 1'h1, 1'h0},
        '{10'h002, 4'h8, 1'h0, 2'h0, 32'h50, 32'h3, 1'h0, 1'h0},
        '{10'h003, 4'h0, 1'h1, 2'h2, 32'h7, 32'h8, 1'h0, 1'h1}};

    dam_mode_ctrl u_dut (.*);
    dam_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .bus_valid(bus_valid),
                         .bus_dual(bus_dual), .imp_count(imp_count));

    always #4 aclk = ~aclk;

    function automatic logic [31:0] flip(input logic [31:0] v);
        for (int n = 0; n < 32; n++) flip[31-n] = v[n];
    endfunction
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_done = 1'b0;
        logic w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'h1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 0;
            end
            if (!w_done && s_axi_wready === 1'h1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        b_got = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        rd_got = s_axi_rdata;
        r_got = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic wreg(input logic [1:0] k, input logic [3:0] n, input logic [31:0] d);
        @(posedge aclk);
        wr_valid <= 1; wr_kind <= k; wr_num <= n; wr_data <= d;
        @(posedge aclk);
        wr_valid <= 0;
    endtask
    task automatic op(input logic [3:0] i, input logic [3:0] m, input logic p,
                      input logic [1:0] w);
        @(posedge aclk);
        op_valid <= 1; op_index <= i; op_modify <= m; op_pre <= p; op_wsize <= w;
        @(posedge aclk);
        op_valid <= 0;
        #1;
    endtask
    task automatic results;
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        #1;
        `CHK(mode_bits, MODE_RST)
        `CHK(bus_valid, 1'h0)
        for (int k = 0; k < 9; k++) begin
            r = rows[k];
            axi_wr(OFS_MODE, {22'h0, r.mode});
            wreg(K_INDEX, r.idx, r.i);
            wreg(K_MODIFY, r.idx, r.m);
            e = r.pre ? r.m + r.i : (r.rv ? flip(r.i) : r.i);
            st = (r.ws == WS_SHORT) ? SW_STEP : NW_STEP;
            op(r.idx, r.idx, r.pre, r.ws);
            `CHK(bus_addr_explicit, e)
            if (r.dual) `CHK(bus_addr_implicit, e + st)
            `CHK(bus_dual, r.dual)
            `CHK(bus_pm, r.idx[B_GEN])
            op(r.idx, r.idx, r.pre, r.ws);
            e = r.pre ? e : (r.rv ? flip(r.i + r.m) : r.i + r.m);
            `CHK(bus_addr_explicit, e)
            n_imp += {7'h0, r.dual} << 1;
        end
        for (int k = 1; k >= 0; k--) begin
            axi_wr(OFS_MODE, k);
            wreg(K_INDEX, 4'hA, 32'hA5A5_0008);
            @(posedge aclk);
            rd_valid <= 1; rd_kind <= K_INDEX; rd_num <= 4'hA;
            @(posedge aclk);
            rd_valid <= 0;
            #1;
            `CHK(dreg_data, 32'hA5A5_0008)
            `CHK(dreg_y_we, k[0])
        end
        axi_wr(OFS_MODE, 32'h1);
        wreg(K_INDEX, 4'h3, 32'h55);
        wr_cond_x <= 0;
        wreg(K_INDEX, 4'h3, 32'h77);
        wr_cond_x <= 1;
        op(4'h3, 4'hC, 1'h1, 2'h0);
        `CHK(bus_addr_explicit, 32'h55)
        axi_wr(OFS_MODE, 32'h0);
        wreg(K_INDEX, 4'h4, 32'hAAA);
        axi_wr(OFS_MODE, 32'h1 << (B_BANK_LSB + 1));
        @(posedge aclk);
        wreg(K_INDEX, 4'h4, 32'hBBB);
        op(4'h4, 4'hC, 1'h1, 2'h0);
        `CHK(bus_addr_explicit, 32'hBBB)
        op(4'h3, 4'hC, 1'h1, 2'h0);
        `CHK(bus_addr_explicit, 32'h55)
        axi_rd(OFS_STATUS);
        `CHK(rd_got[3:0], 4'h2)
        axi_wr(OFS_MODE, 32'h0);
        @(posedge aclk);
        op(4'h4, 4'hC, 1'h1, 2'h0);
        `CHK(bus_addr_explicit, 32'hAAA)
        wreg(K_BASE, 4'h6, 32'h900);
        op(4'h6, 4'hC, 1'h1, 2'h0);
        `CHK(bus_addr_explicit, 32'h900)
        axi_wr(OFS_MASK, 32'h3);
        `CHK(b_got, RESP_OKAY)
        axi_wr(OFS_FORCE, 32'h2);
        axi_wr(OFS_MODE, 32'h81);
        @(posedge aclk);
        isr_entry <= 1;
        @(posedge aclk);
        isr_entry <= 0;
        #1;
        `CHK(mode_bits, (10'h081 & ~10'h003) | (10'h002 & 10'h003))
        `CHK(imp_count, n_imp)
        axi_wr(4'h2, 32'h3FF);
        `CHK(b_got, RESP_SLVERR)
        `CHK(mode_bits, 10'h082)
        axi_rd(OFS_MODE);
        `CHK(r_got, RESP_OKAY)
        `CHK(rd_got, 32'h0000_0082)
        axi_rd(4'h2);
        `CHK(r_got, RESP_SLVERR)
        `CHK(rd_got, 32'h0000_0000)
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        #1;
        `CHK(mode_bits, MODE_RST)
        `CHK(s_axi_bvalid, 1'h0)
        results();
    end
endmodule
